// file: verilog/ep_ctrl_pkg.sv
// shared constants for the endpoint control block
package ep_ctrl_pkg;
  localparam int NUM_EP = 8;
  localparam int EP_W = 3;
  localparam int CNT_W = 11;
  localparam int DMA_CH = 3;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STALL = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_EP_SEL = 8'h0c;
  localparam logic [7:0] REG_EP_STAT = 8'h10;
  localparam logic [7:0] REG_EP_CMD = 8'h14;
  localparam logic [7:0] REG_RX_COUNT = 8'h18;
  localparam logic [7:0] REG_DMA_MAP = 8'h1c;
  localparam logic [7:0] REG_IRQ_STAT = 8'h20;
  localparam logic [7:0] REG_IRQ_MASK = 8'h24;
  localparam logic [7:0] REG_AUTO_SET = 8'h28;
  localparam logic [7:0] REG_MAXPKT = 8'h2c;
  // control register fields
  localparam int CTRL_DEV_MODE = 0;
  // ep command fields
  localparam int CMD_STALL_SET = 0;
  localparam int CMD_STALL_CLR = 1;
  localparam int CMD_TOG_CLR = 2;
  localparam int CMD_SEND = 3;
  localparam int CMD_DIR = 4;
  localparam int CMD_TYPE_LSB = 8;
  // direction select codes
  localparam logic device_in_direction_select = 1'b1;
  localparam logic device_out_direction_select = 1'b0;
  localparam logic host_transmit_direction_select = 1'b1;
  localparam logic host_receive_direction_select = 1'b0;
  // endpoint status layout
  localparam int ST_IN_PEND = 0;
  localparam int ST_IN_BUSY = 1;
  localparam int ST_IN_SENT_STALL = 2;
  localparam int ST_OUT_RDY = 3;
  localparam int ST_OUT_SENT_STALL = 4;
  localparam int ST_W = 5;
  // irq bits
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX_DONE = 1;
  localparam int IRQ_STALL = 2;
  localparam int IRQ_W = 3;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
  typedef enum logic [2:0] {
    host_outbound_transaction_type = 3'b000,
    device_inbound_transaction_type = 3'b001,
    final_control_in_transaction_type = 3'b010,
    control_setup_transaction_type = 3'b011,
    control_status_transaction_type = 3'b100
  } trans_type_t;
  typedef enum logic [1:0] {
    HS_ACK = 2'b00,
    HS_NAK = 2'b01,
    HS_STALL = 2'b10
  } handshake_t;
  localparam logic SPEED_FULL = 1'b0;
  localparam logic SPEED_HIGH = 1'b1;
endpackage : ep_ctrl_pkg

// file: verilog/ep_rx_counter.sv
// per-endpoint receive byte count and ready flag
`timescale 1ns/100ps
module ep_rx_counter #(
  parameter int CNT_WIDTH = ep_ctrl_pkg::CNT_W
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic byte_strobe,
  input wire logic pkt_end,
  input wire logic pkt_release,
  output logic [CNT_WIDTH-1:0] byte_count,
  output logic pkt_ready
);
  import ep_ctrl_pkg::*;
  logic [CNT_WIDTH-1:0] count_q, count_d;
  logic ready_q, ready_d;

  initial begin
    if (CNT_WIDTH < 1) $error("CNT_WIDTH too small");
  end

  always_comb begin
    count_d = count_q;
    ready_d = ready_q;
    if (pkt_release) begin
      count_d = '0;
      ready_d = 1'b0;
    end
    if (byte_strobe && !ready_q) begin
      count_d = count_q + 1'b1;
    end
    // empty packet still marks ready with zero count
    if (pkt_end) begin
      ready_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      count_q <= '0;
      ready_q <= 1'b0;
    end else begin
      count_q <= count_d;
      ready_q <= ready_d;
    end
  end

  assign byte_count = count_q;
  assign pkt_ready = ready_q;
endmodule : ep_rx_counter

// file: verilog/ep_tx_counter.sv
// per-endpoint transmit load count and auto-send detect
`timescale 1ns/100ps
module ep_tx_counter #(
  parameter int CNT_WIDTH = ep_ctrl_pkg::CNT_W
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic load_strobe,
  input wire logic clear,
  input wire logic [CNT_WIDTH-1:0] max_packet,
  output logic [CNT_WIDTH-1:0] load_count,
  output logic reached_full
);
  import ep_ctrl_pkg::*;
  logic [CNT_WIDTH-1:0] count_q, count_d;

  initial begin
    if (CNT_WIDTH < 1) $error("CNT_WIDTH too small");
  end

  always_comb begin
    count_d = count_q;
    if (clear) begin
      count_d = '0;
    end else if (load_strobe) begin
      count_d = count_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign load_count = count_q;
  assign reached_full = load_strobe && !clear && max_packet != '0 &&
    (count_q + 1'b1) == max_packet;
endmodule : ep_tx_counter

// file: verilog/usb_endpoint_control.sv
// endpoint control: stall, status, toggles, send, dma map, registers
//
// Function
// - IN stall sets only IN half
// - OUT stall sets only OUT half
// - stall clear affects selected half only
// - write-one clears exactly supplied status bits
// - dual-role part switches to device role
// - report negotiated speed high or full
// - rx byte count readable per endpoint
// - empty packet is ready, count zero
// - pending tx blocks new FIFO loads
// - send carries one of five types
// - busy visible, second trigger rejected
// - toggle reset per direction, any role; code refuses it on ep0
// - rx channels rx only, tx tx only
// - three rx, three tx channels, not ep0
// - no remap capability means no effect
// - auto-send when full packet loaded
//
// Local design decisions: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
module usb_endpoint_control #(
  parameter int NUM_ENDPOINTS = ep_ctrl_pkg::NUM_EP,
  parameter bit DUAL_ROLE = 1'b1,
  parameter bit DMA_REMAP = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic link_high_speed,
  input wire logic link_token_valid,
  input wire logic [ep_ctrl_pkg::EP_W-1:0] link_token_ep,
  input wire logic link_token_in,
  input wire logic link_rx_byte,
  input wire logic link_rx_end,
  input wire logic link_tx_done,
  input wire logic fifo_load_strobe,
  input wire logic [ep_ctrl_pkg::EP_W-1:0] fifo_load_ep,
  output logic fifo_load_ready,
  output logic [1:0] link_handshake,
  output logic link_handshake_valid,
  output logic tx_start,
  output ep_ctrl_pkg::trans_type_t tx_type,
  output logic [ep_ctrl_pkg::EP_W-1:0] tx_ep,
  output logic [ep_ctrl_pkg::NUM_EP-1:0] data_toggle_in,
  output logic [ep_ctrl_pkg::NUM_EP-1:0] data_toggle_out,
  output logic device_role,
  output logic irq
);
  import ep_ctrl_pkg::*;

  initial begin
    if (NUM_ENDPOINTS != NUM_EP) $error("NUM_ENDPOINTS must equal NUM_EP");
  end

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [NUM_EP-1:0] stall_in_q, stall_in_d, stall_out_q, stall_out_d;
  logic [NUM_EP-1:0] pend_q, pend_d, busy_q, busy_d;
  logic [NUM_EP-1:0] in_sstall_q, in_sstall_d;
  logic [NUM_EP-1:0] out_sstall_q, out_sstall_d;
  logic [NUM_EP-1:0] tog_in_q, tog_in_d, tog_out_q, tog_out_d;
  logic [NUM_EP-1:0] auto_q, auto_d;
  logic [CNT_W-1:0] maxpkt_q, maxpkt_d;
  logic [EP_W-1:0] sel_q, sel_d;
  logic role_q, role_d;
  logic [EP_W-1:0] rx_map_q [DMA_CH];
  logic [EP_W-1:0] rx_map_d [DMA_CH];
  logic [EP_W-1:0] tx_map_q [DMA_CH];
  logic [EP_W-1:0] tx_map_d [DMA_CH];
  logic [IRQ_W-1:0] irq_st_q, irq_st_d, irq_mask_q, irq_mask_d;
  logic [31:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic start_q, start_d;
  trans_type_t type_q, type_d;
  logic [EP_W-1:0] txep_q, txep_d;
  logic [1:0] hs_q, hs_d;
  logic hsv_q, hsv_d;
  logic irq_q, irq_d;
  logic load_rdy_q, load_rdy_d;

  logic [CNT_W-1:0] rx_count [NUM_EP];
  logic [NUM_EP-1:0] rx_ready, tx_full, rx_rel, tx_clr, ld_stb, rx_stb, rx_end;

  ////////////////////////////////////////////////////////////////////////
  // per-endpoint counters
  for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
    assign rx_stb[e] = link_rx_byte && !link_token_in &&
      link_token_ep == EP_W'(e) && !stall_out_q[e];
    assign rx_end[e] = link_rx_end && link_token_ep == EP_W'(e) &&
      !stall_out_q[e];
    assign ld_stb[e] = fifo_load_strobe && fifo_load_ep == EP_W'(e) &&
      !pend_q[e];
    ep_rx_counter #(.CNT_WIDTH(CNT_W)) u_rx (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .byte_strobe(rx_stb[e]),
      .pkt_end(rx_end[e]),
      .pkt_release(rx_rel[e]),
      .byte_count(rx_count[e]),
      .pkt_ready(rx_ready[e])
    );
    ep_tx_counter #(.CNT_WIDTH(CNT_W)) u_tx (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .load_strobe(ld_stb[e]),
      .clear(tx_clr[e]),
      .max_packet(maxpkt_q),
      .load_count(),
      .reached_full(tx_full[e])
    );
  end

  function automatic logic [ST_W-1:0] ep_status(input logic [EP_W-1:0] e);
    logic [ST_W-1:0] s;
    s = '0;
    s[ST_IN_PEND] = pend_q[e];
    s[ST_IN_BUSY] = busy_q[e];
    s[ST_IN_SENT_STALL] = in_sstall_q[e];
    s[ST_OUT_RDY] = rx_ready[e];
    s[ST_OUT_SENT_STALL] = out_sstall_q[e];
    return s;
  endfunction : ep_status

  ////////////////////////////////////////////////////////////////////////
  // register and endpoint logic
  logic wr, rd, cmd_wr;
  logic [EP_W-1:0] cep;
  logic cdir;
  logic [2:0] ctype;
  logic [1:0] dch;
  logic [EP_W-1:0] dep;
  always_comb begin
    wr = avs_write && !ack_q;
    rd = avs_read && !ack_q;
    cmd_wr = wr && avs_address == REG_EP_CMD && avs_byteenable[0];
    cep = sel_q;
    cdir = avs_writedata[CMD_DIR];
    ctype = avs_writedata[CMD_TYPE_LSB +: 3];
    dch = avs_writedata[1:0];
    dep = avs_writedata[8 +: EP_W];
    stall_in_d = stall_in_q;
    stall_out_d = stall_out_q;
    pend_d = pend_q;
    busy_d = busy_q;
    in_sstall_d = in_sstall_q;
    out_sstall_d = out_sstall_q;
    tog_in_d = tog_in_q;
    tog_out_d = tog_out_q;
    auto_d = auto_q;
    maxpkt_d = maxpkt_q;
    sel_d = sel_q;
    role_d = role_q;
    rx_map_d = rx_map_q;
    tx_map_d = tx_map_q;
    irq_st_d = irq_st_q;
    irq_mask_d = irq_mask_q;
    rdata_d = rdata_q;
    ack_d = 1'b0;
    start_d = 1'b0;
    type_d = type_q;
    txep_d = txep_q;
    hs_d = hs_q;
    hsv_d = 1'b0;
    rx_rel = '0;
    tx_clr = '0;
    // software side
    if (wr || rd) ack_d = 1'b1;
    if (wr && avs_byteenable[0]) begin
      unique case (avs_address)
        REG_CTRL: if (DUAL_ROLE && avs_writedata[CTRL_DEV_MODE])
          role_d = 1'b1;
        REG_EP_SEL: sel_d = avs_writedata[EP_W-1:0];
        REG_EP_STAT: begin
          // write-one clear of the selected endpoint's status
          if (avs_writedata[ST_IN_SENT_STALL]) in_sstall_d[cep] = 1'b0;
          if (avs_writedata[ST_OUT_SENT_STALL]) out_sstall_d[cep] = 1'b0;
          if (avs_writedata[ST_OUT_RDY]) rx_rel[cep] = 1'b1;
        end
        REG_IRQ_STAT: irq_st_d = irq_st_q & ~avs_writedata[IRQ_W-1:0];
        REG_IRQ_MASK: irq_mask_d = avs_writedata[IRQ_W-1:0];
        REG_AUTO_SET: auto_d = avs_writedata[NUM_EP-1:0];
        REG_DMA_MAP: begin
          // remap refused for ep0 and bad channel; absent remap is a no-op
          if (DMA_REMAP && dep != '0 && dch < 2'(DMA_CH)) begin
            if (avs_writedata[4]) tx_map_d[dch] = dep;
            else rx_map_d[dch] = dep;
          end
        end
        default: ;
      endcase
    end
    if (wr && avs_address == REG_MAXPKT && avs_byteenable[1:0] == 2'b11)
      maxpkt_d = avs_writedata[CNT_W-1:0];
    if (cmd_wr) begin
      if (avs_writedata[CMD_STALL_SET]) begin
        if (cdir == device_in_direction_select) stall_in_d[cep] = 1'b1;
        else stall_out_d[cep] = 1'b1;
      end
      if (avs_writedata[CMD_STALL_CLR]) begin
        if (cdir == device_in_direction_select) stall_in_d[cep] = 1'b0;
        else stall_out_d[cep] = 1'b0;
      end
      // no toggle reset on ep0
      if (avs_writedata[CMD_TOG_CLR] && cep != '0) begin
        if (cdir == device_in_direction_select) tog_in_d[cep] = 1'b0;
        else tog_out_d[cep] = 1'b0;
      end
      // busy endpoint drops the trigger; software sees it in status
      if (avs_writedata[CMD_SEND] && !busy_q[cep] &&
          ctype <= 3'(control_status_transaction_type)) begin
        start_d = 1'b1;
        type_d = trans_type_t'(ctype);
        txep_d = cep;
        busy_d[cep] = 1'b1;
        pend_d[cep] = 1'b1;
      end
    end
    // auto start on a full packet
    for (int e = 0; e < NUM_EP; e++) begin
      if (auto_q[e] && tx_full[e] && !busy_d[e]) begin
        start_d = 1'b1;
        type_d = device_inbound_transaction_type;
        txep_d = EP_W'(e);
        busy_d[e] = 1'b1;
        pend_d[e] = 1'b1;
      end
    end
    // link side
    if (link_token_valid) begin
      hsv_d = 1'b1;
      if (link_token_in ? stall_in_q[link_token_ep] :
          stall_out_q[link_token_ep]) begin
        hs_d = HS_STALL;
        if (link_token_in) in_sstall_d[link_token_ep] = 1'b1;
        else out_sstall_d[link_token_ep] = 1'b1;
        irq_st_d[IRQ_STALL] = 1'b1;
      end else if (!link_token_in && rx_ready[link_token_ep]) begin
        hs_d = HS_NAK;
      end else begin
        hs_d = HS_ACK;
      end
    end
    if (link_rx_end && !stall_out_q[link_token_ep]) begin
      irq_st_d[IRQ_RX] = 1'b1;
      tog_out_d[link_token_ep] = ~tog_out_q[link_token_ep];
    end
    if (link_tx_done) begin
      busy_d[txep_q] = 1'b0;
      pend_d[txep_q] = 1'b0;
      tx_clr[txep_q] = 1'b1;
      tog_in_d[txep_q] = ~tog_in_q[txep_q];
      irq_st_d[IRQ_TX_DONE] = 1'b1;
    end
    // read mux
    if (rd) begin
      unique case (avs_address)
        REG_CTRL: rdata_d = {31'h0, role_q};
        REG_STATUS: rdata_d = {31'h0,
          link_high_speed ? SPEED_HIGH : SPEED_FULL};
        REG_STALL: rdata_d = {16'h0, stall_out_q, stall_in_q};
        REG_EP_SEL: rdata_d = {29'h0, sel_q};
        REG_EP_STAT: rdata_d = {27'h0, ep_status(sel_q)};
        REG_RX_COUNT: rdata_d = {21'h0, rx_count[sel_q]};
        REG_IRQ_STAT: rdata_d = {29'h0, irq_st_q};
        REG_IRQ_MASK: rdata_d = {29'h0, irq_mask_q};
        REG_AUTO_SET: rdata_d = {24'h0, auto_q};
        REG_MAXPKT: rdata_d = {21'h0, maxpkt_q};
        REG_DMA_MAP: rdata_d = {14'h0, tx_map_q[2], tx_map_q[1],
          tx_map_q[0], rx_map_q[2], rx_map_q[1], rx_map_q[0]};
        default: rdata_d = RD_UNMAPPED;
      endcase
    end
    irq_d = |(irq_st_d & irq_mask_d);
    load_rdy_d = !pend_d[fifo_load_ep];
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stall_in_q <= '0;
      stall_out_q <= '0;
      pend_q <= '0;
      busy_q <= '0;
      in_sstall_q <= '0;
      out_sstall_q <= '0;
      tog_in_q <= '0;
      tog_out_q <= '0;
      auto_q <= '0;
      maxpkt_q <= '0;
      sel_q <= '0;
      role_q <= 1'b0;
      for (int c = 0; c < DMA_CH; c++) begin
        rx_map_q[c] <= EP_W'(c + 1);
        tx_map_q[c] <= EP_W'(c + 1);
      end
      irq_st_q <= '0;
      irq_mask_q <= '0;
      rdata_q <= '0;
      ack_q <= 1'b0;
      start_q <= 1'b0;
      type_q <= host_outbound_transaction_type;
      txep_q <= '0;
      hs_q <= HS_ACK;
      hsv_q <= 1'b0;
      irq_q <= 1'b0;
      load_rdy_q <= 1'b0;
    end else begin
      stall_in_q <= stall_in_d;
      stall_out_q <= stall_out_d;
      pend_q <= pend_d;
      busy_q <= busy_d;
      in_sstall_q <= in_sstall_d;
      out_sstall_q <= out_sstall_d;
      tog_in_q <= tog_in_d;
      tog_out_q <= tog_out_d;
      auto_q <= auto_d;
      maxpkt_q <= maxpkt_d;
      sel_q <= sel_d;
      role_q <= role_d;
      rx_map_q <= rx_map_d;
      tx_map_q <= tx_map_d;
      irq_st_q <= irq_st_d;
      irq_mask_q <= irq_mask_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
      start_q <= start_d;
      type_q <= type_d;
      txep_q <= txep_d;
      hs_q <= hs_d;
      hsv_q <= hsv_d;
      irq_q <= irq_d;
      load_rdy_q <= load_rdy_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  // waitrequest falls one cycle after the request is seen
  assign avs_waitrequest = !ack_q;
  assign avs_readdata = rdata_q;
  assign tx_start = start_q;
  assign tx_type = type_q;
  assign tx_ep = txep_q;
  assign link_handshake = hs_q;
  assign link_handshake_valid = hsv_q;
  assign data_toggle_in = tog_in_q;
  assign data_toggle_out = tog_out_q;
  assign device_role = role_q;
  assign irq = irq_q;
  assign fifo_load_ready = load_rdy_q;
endmodule : usb_endpoint_control

// file: testbench/usb_endpoint_control_properties.sv
// concurrent checks on the endpoint control ports
`timescale 1ns/100ps
module usb_endpoint_control_properties (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic link_token_valid,
  input wire logic link_rx_end,
  input wire logic link_tx_done,
  input wire logic [ep_ctrl_pkg::EP_W-1:0] fifo_load_ep,
  input wire logic fifo_load_ready,
  input wire logic link_handshake_valid,
  input wire logic tx_start,
  input wire ep_ctrl_pkg::trans_type_t tx_type,
  input wire logic [ep_ctrl_pkg::EP_W-1:0] tx_ep,
  input wire logic device_role,
  input wire logic irq
);
  import ep_ctrl_pkg::*;
  logic [NUM_EP-1:0] busy_q, busy_d;
  logic ev;
  assign ev = link_rx_end || link_tx_done || link_token_valid || avs_write;
  // sends in flight
  always_comb begin
    busy_d = busy_q;
    if (link_tx_done) busy_d[tx_ep] = 1'b0;
    if (tx_start) busy_d[tx_ep] = 1'b1;
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) busy_q <= '0;
    else busy_q <= busy_d;
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  wait_ack_a:
    assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("no answer");
  wait_pulse_a:
    assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
  unmapped_zero_a:
    assert property (avs_read && !avs_waitrequest && avs_address > 8'h2f
      |-> avs_readdata == RD_UNMAPPED) else $error("unmapped read not 0");
  hs_follow_a:
    assert property (link_token_valid |=> link_handshake_valid)
      else $error("no handshake");
  hs_cause_a:
    assert property (link_handshake_valid |-> $past(link_token_valid))
      else $error("stray handshake");
  type_legal_a:
    assert property (tx_start |-> tx_type <= control_status_transaction_type)
      else $error("bad send type");
  busy_refuse_a:
    assert property (tx_start |-> !busy_q[tx_ep])
      else $error("second send while busy");
  load_block_a:
    assert property (tx_start && fifo_load_ep == tx_ep |=> !fifo_load_ready)
      else $error("load ready while pending");
  role_keep_a:
    assert property (!$fell(device_role)) else $error("device role dropped");
  irq_cause_a:
    assert property ($rose(irq) |-> $past(ev, 1) || $past(ev, 2)
      || $past(ev, 3)) else $error("stray irq");
endmodule : usb_endpoint_control_properties

bind usb_endpoint_control usb_endpoint_control_properties chk (.*);

// file: testbench/usb_host_model.sv
// host controller model on the link side of the endpoint block
`timescale 1ns/100ps
module usb_host_model (
  input wire logic core_clk,
  input wire logic tx_start,
  output logic link_token_valid,
  output logic [ep_ctrl_pkg::EP_W-1:0] link_token_ep,
  output logic link_token_in,
  output logic link_rx_byte,
  output logic link_rx_end,
  output logic link_tx_done
);
  import ep_ctrl_pkg::*;
  int done_delay = 2;
  initial {link_token_valid, link_token_ep, link_token_in, link_rx_byte,
    link_rx_end, link_tx_done} = '0;
  // one send at a time; a slow host just waits longer
  always @(posedge core_clk) begin
    if (tx_start === 1'b1) begin
      repeat (done_delay) @(posedge core_clk);
      link_tx_done <= 1'b1;
      @(posedge core_clk);
      link_tx_done <= 1'b0;
    end
  end
  task automatic token(input logic [2:0] e, input logic dir_in);
    link_token_valid <= 1'b1;
    link_token_ep <= e;
    link_token_in <= dir_in;
    @(posedge core_clk);
    link_token_valid <= 1'b0;
    @(posedge core_clk);
  endtask : token
  task automatic out_packet(input logic [2:0] e, input int n);
    token(e, 1'b0);
    link_rx_byte <= (n > 0);
    repeat (n) @(posedge core_clk);
    link_rx_byte <= 1'b0;
    link_rx_end <= 1'b1;
    @(posedge core_clk);
    link_rx_end <= 1'b0;
    // endpoint field is stale outside a packet
    link_token_ep <= ~e;
    @(posedge core_clk);
  endtask : out_packet
endmodule : usb_host_model

// file: testbench/usb_endpoint_control_tb.sv
// self-checking bench for the endpoint control block
`timescale 1ns/100ps
module usb_endpoint_control_tb;
  import ep_ctrl_pkg::*;
  localparam int DIN = 1 << CMD_DIR, STS = 1 << CMD_STALL_SET;
  localparam int STC = 1 << CMD_STALL_CLR, TGC = 1 << CMD_TOG_CLR;
  localparam int SND = 1 << CMD_SEND;
  logic core_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic avs_waitrequest, fifo_load_ready, link_handshake_valid, tx_start;
  logic link_high_speed = 1'b0, fifo_load_strobe = 1'b0, device_role, irq;
  logic [3:0] avs_byteenable = 4'hf;
  logic link_token_valid, link_token_in, link_rx_byte, link_rx_end;
  logic link_tx_done;
  logic [EP_W-1:0] fifo_load_ep = 3'h0, link_token_ep, tx_ep, ep;
  logic [1:0] link_handshake;
  trans_type_t tx_type;
  logic [NUM_EP-1:0] data_toggle_in, data_toggle_out;
  logic [63:0] rd_q[$];
  logic hs_q[$];
  logic [5:0] tx_q[$];
  logic [2:0] rxm[3] = '{3'h1, 3'h2, 3'h3}, txm[3] = '{3'h1, 3'h2, 3'h3};
  int mismatches = 0, n_compared = 0, seed = 32'h268896fa, v, n, ch;
  usb_endpoint_control dut (.*);
  usb_host_model host (.*);
  initial forever #20 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic note(input bit bad, input string what);
    n_compared++;
    if (bad) begin
      mismatches++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : note
  task automatic cmp_rd(input logic [31:0] got, input logic [63:0] e);
    note((got & e[63:32]) !== e[31:0], "read data");
  endtask : cmp_rd
  task automatic cmp_tx(input logic [5:0] got, input logic [5:0] e);
    note(got !== e, "send endpoint or type");
  endtask : cmp_tx
  task automatic cmp_hs(input logic [1:0] got, input logic stall);
    note(stall ? got !== HS_STALL : !(got === HS_ACK || got === HS_NAK),
      "handshake");
  endtask : cmp_hs
  task automatic cmp_bit(input logic got, input logic e);
    note(got !== e, "output level");
  endtask : cmp_bit
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  // held until waitrequest is seen low
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge core_clk);
    while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    rd_q.push_back({m, e});
    bus(a, 1'b0, 32'h0);
  endtask : rd
  task automatic cmd(input logic [2:0] e, input logic [31:0] c);
    wr(REG_EP_SEL, 32'(e));
    wr(REG_EP_CMD, c);
  endtask : cmd
  task automatic look();
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
  endtask : look
  task automatic irq_is(input logic e);
    look();
    cmp_bit(irq, e);
    @(posedge core_clk);
  endtask : irq_is
  task automatic wait_done();
    while (link_tx_done !== 1'b1) @(posedge core_clk);
    @(posedge core_clk);
  endtask : wait_done
  task automatic load(input logic [2:0] e, input int k);
    fifo_load_ep <= e;
    fifo_load_strobe <= 1'b1;
    repeat (k) @(posedge core_clk);
    fifo_load_strobe <= 1'b0;
    @(posedge core_clk);
  endtask : load
  function automatic logic [2:0] rnd_ep();
    v = $random(seed);
    return 3'(1 + (v & 32'hff) % 7);
  endfunction : rnd_ep
  function automatic logic [31:0] dma_exp();
    dma_exp = 32'h0;
    for (int c = 0; c < 3; c++) begin
      dma_exp[3*c +: 3] = rxm[c];
      dma_exp[9+3*c +: 3] = txm[c];
    end
  endfunction : dma_exp
  ////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (rd_q.size() == 0) note(1'b1, "stray read");
      else cmp_rd(avs_readdata, rd_q.pop_front());
    end
    if (tx_start === 1'b1) begin
      if (tx_q.size() == 0) note(1'b1, "stray send");
      else cmp_tx({tx_ep, tx_type}, tx_q.pop_front());
    end
    if (link_handshake_valid === 1'b1) begin
      if (hs_q.size() == 0) note(1'b1, "stray handshake");
      else cmp_hs(link_handshake, hs_q.pop_front());
    end
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(REG_STALL, 32'h0, 32'hffff);
    rd(8'h40, 32'h0, 32'hffff_ffff);
    rd(REG_DMA_MAP, dma_exp(), 32'h3_ffff);
    avs_byteenable <= 4'he;
    wr(REG_CTRL, 32'h1);
    avs_byteenable <= 4'hf;
    rd(REG_CTRL, 32'h0, 32'h1);
    wr(REG_CTRL, 32'h1);
    look();
    cmp_bit(device_role, 1'b1);
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk);
      link_high_speed <= k[0];
      rd(REG_STATUS, 32'(k), 32'h1);
    end
    $display("test role and speed done");
    ep = rnd_ep();
    cmd(ep, STS | DIN);
    rd(REG_STALL, 32'h1 << ep, 32'hffff);
    hs_q.push_back(1'b1);
    host.token(ep, 1'b1);
    hs_q.push_back(1'b0);
    host.token(ep, 1'b0);
    cmd(ep, STS);
    rd(REG_STALL, 32'h101 << ep, 32'hffff);
    cmd(ep, STC | DIN);
    rd(REG_STALL, 32'h100 << ep, 32'hffff);
    hs_q.push_back(1'b1);
    host.token(ep, 1'b0);
    hs_q.push_back(1'b0);
    host.token(ep, 1'b1);
    cmd(ep, STC);
    rd(REG_STALL, 32'h0, 32'hffff);
    rd(REG_EP_STAT, 32'h14, 32'h1c);
    wr(REG_EP_STAT, 32'h4);
    rd(REG_EP_STAT, 32'h10, 32'h1c);
    wr(REG_EP_STAT, 32'h10);
    rd(REG_EP_STAT, 32'h0, 32'h1c);
    irq_is(1'b0);
    wr(REG_IRQ_MASK, 32'h4);
    irq_is(1'b1);
    wr(REG_IRQ_STAT, 32'h4);
    irq_is(1'b0);
    $display("test stall and irq done");
    for (int k = 0; k < 2; k++) begin
      ep = rnd_ep();
      n = k ? 0 : 1 + (v & 32'h3f);
      hs_q.push_back(1'b0);
      host.out_packet(ep, n);
      wr(REG_EP_SEL, 32'(ep));
      rd(REG_RX_COUNT, 32'(n), 32'h7ff);
      rd(REG_EP_STAT, 32'h8, 32'h8);
      wr(REG_EP_STAT, 32'h8);
      rd(REG_RX_COUNT, 32'h0, 32'h7ff);
    end
    rd(REG_IRQ_STAT, 32'h1, 32'h1);
    $display("test receive done");
    for (int t = 0; t < 8; t++) begin
      ep = (t > 1) ? 3'h0 : rnd_ep();
      host.done_delay = 20 + 5 * t;
      if (t < 5) tx_q.push_back({ep, 3'(t)});
      cmd(ep, SND | DIN | (32'(t) << CMD_TYPE_LSB));
      if (t < 5) begin
        rd(REG_EP_STAT, 32'h3, 32'h3);
        cmd(ep, SND | DIN | 32'h100);
        wait_done();
        rd(REG_EP_STAT, 32'h0, 32'h3);
      end
      if (t == 1) begin
        cmd(ep, TGC | DIN);
        cmd(ep, TGC);
        look();
        cmp_bit(data_toggle_in[ep], 1'b0);
        cmp_bit(data_toggle_out[ep], 1'b0);
        @(posedge core_clk);
      end
    end
    $display("test send done");
    ep = rnd_ep();
    wr(REG_MAXPKT, 32'h4);
    wr(REG_AUTO_SET, 32'h1 << ep);
    host.done_delay = 30;
    tx_q.push_back({ep, device_inbound_transaction_type});
    load(ep, 4);
    look();
    cmp_bit(fifo_load_ready, 1'b0);
    @(posedge core_clk);
    load(ep, 4);
    wait_done();
    host.done_delay = 1;
    tx_q.push_back({ep, device_inbound_transaction_type});
    load(ep, 4);
    wait_done();
    $display("test auto send done");
    for (int k = 0; k < 8; k++) begin
      ep = (k == 6) ? 3'h0 : rnd_ep();
      ch = (k == 7) ? 3 : k % 3;
      wr(REG_DMA_MAP, 32'(ep) << 8 | 32'(k / 3 % 2) << 4 | 32'(ch));
      if (k < 3) rxm[ch] = ep;
      else if (k < 6) txm[ch] = ep;
    end
    rd(REG_DMA_MAP, dma_exp(), 32'h3_ffff);
    $display("test dma map done");
    repeat (5) @(posedge core_clk);
    note(rd_q.size() + tx_q.size() + hs_q.size() != 0, "results missing");
    end_sim();
  end
endmodule : usb_endpoint_control_tb
